// File: rtl/ptbl_core.sv
// What this block does
// - stage raises alarm when fault is detected
// - general alarm ORs all non-supervision stage alarms
// - trip only when fault outlasts stage delay
// - general trip ORs all non-supervision stage trips
// - trip command when tripped and not blocked
// - supervision-only stage has no trip command
// - supervision-only stage excluded from collective signals
// - per-phase collective alarm from phase-selective stages
// - per-phase collective trip from phase-selective stages
// - ground stage alarm sets ground collective alarm
// - breaker opens only for assigned trip commands
// - master inactive inhibits every stage output
// - inactive stage produces no alarm or trip
// - permanent disable holds trip command low
// - master external block stops all protection
// - stage blocked while permitted source asserted
// - trip-block source suppresses permitted trip command
// - motor start loads all timers, blocks assigned
`timescale 1ns/1ns
`default_nettype none
module ptbl_core
	import ptbl_pkg::*;
#(
	parameter int NSTAGE = PTBL_NSTAGE,
	parameter int NBRK   = PTBL_NBRK,
	parameter int NMST   = PTBL_NMST,
	parameter int TW     = PTBL_TW
) (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              master_active,
	input  wire logic                              master_ext_block_permit,
	input  wire logic                              master_ext_block_source_a,
	input  wire logic                              master_ext_block_source_b,
	input  wire logic                              master_trip_cmd_disable,
	input  wire logic                              master_trip_block_permit,
	input  wire logic                              master_trip_block_source,
	input  wire logic                              motor_start,
	input  wire logic [NMST-1:0][TW-1:0]           motor_start_time,
	input  wire logic [NSTAGE-1:0]                 fault_det,
	input  wire logic [NSTAGE-1:0][PTBL_NPH-1:0]   fault_phase,
	input  wire logic [NSTAGE-1:0][TW-1:0]         stage_delay,
	input  wire logic [NSTAGE-1:0]                 stage_active,
	input  wire logic [NSTAGE-1:0]                 superv_only,
	input  wire logic [NSTAGE-1:0]                 phase_selective,
	input  wire logic [NSTAGE-1:0]                 ground_stage,
	input  wire logic [NSTAGE-1:0]                 trip_cmd_disable,
	input  wire logic [NSTAGE-1:0]                 ext_block_permit,
	input  wire logic [NSTAGE-1:0]                 ext_block_source_a,
	input  wire logic [NSTAGE-1:0]                 ext_block_source_b,
	input  wire logic [NSTAGE-1:0]                 trip_block_permit,
	input  wire logic [NSTAGE-1:0]                 trip_block_source,
	input  wire logic [NSTAGE-1:0][NMST-1:0]       motor_start_assign,
	input  wire logic [NBRK-1:0][NSTAGE-1:0]       trip_assign,
	output logic      [NSTAGE-1:0]                 stage_alarm,
	output logic      [NSTAGE-1:0]                 stage_trip,
	output logic      [NSTAGE-1:0]                 trip_command,
	output logic                                   general_alarm,
	output logic                                   general_trip,
	output logic                                   general_alarm_ground,
	output logic                                   general_alarm_phase_a,
	output logic                                   general_alarm_phase_b,
	output logic                                   general_alarm_phase_c,
	output logic                                   general_trip_phase_a,
	output logic                                   general_trip_phase_b,
	output logic                                   general_trip_phase_c,
	output logic      [NBRK-1:0]                   breaker_open,
	output logic      [NMST-1:0]                   motor_start_blocking
);

	////////////////////////////////////////////////////////////////////////////
	// synchroniser layout: stage sources, then master sources, then motor start
	localparam int SY_A   = 0;
	localparam int SY_B   = NSTAGE;
	localparam int SY_TB  = 2 * NSTAGE;
	localparam int SY_MA  = 3 * NSTAGE;
	localparam int SY_MB  = SY_MA + 1;
	localparam int SY_MTB = SY_MA + 2;
	localparam int SY_MS  = SY_MA + 3;
	localparam int NSYNC  = SY_MA + 4;

	typedef struct packed {
		logic [NSYNC-1:0]              sy1;
		logic [NSYNC-1:0]              sy2;
		logic                          ms_prev;
		logic [NSTAGE-1:0][TW-1:0]     cnt;
		logic [NMST-1:0][TW-1:0]       mst;
		logic [NSTAGE-1:0]             alarm;
		logic [NSTAGE-1:0]             trip;
		logic [NSTAGE-1:0]             cmd;
		logic                          gal;
		logic                          gtr;
		logic                          gnd;
		logic [PTBL_NPH-1:0]           pal;
		logic [PTBL_NPH-1:0]           ptr;
		logic [NBRK-1:0]               brk;
		logic [NMST-1:0]               msb;
	} ptbl_state_s;

	ptbl_state_s s_q;
	ptbl_state_s s_d;
	logic [NSTAGE-1:0] en;
	logic [NSYNC-1:0]  raw;

	assign raw = {motor_start, master_trip_block_source, master_ext_block_source_b,
		master_ext_block_source_a, trip_block_source, ext_block_source_b, ext_block_source_a};

	////////////////////////////////////////////////////////////////////////////
	// stage enable: master, stage setting, external and motor-start blockings
	always_comb begin
		logic mblk;
		logic [NMST-1:0] run;
		run  = '0;
		mblk = master_ext_block_permit & (s_q.sy2[SY_MA] | s_q.sy2[SY_MB]);
		for (int m = 0; m < NMST; m++) begin
			run[m] = (s_q.mst[m] != PTBL_CNT_RST);
		end
		for (int i = 0; i < NSTAGE; i++) begin
			en[i] = master_active & ~mblk & stage_active[i]
				& ~(ext_block_permit[i] & (s_q.sy2[SY_A + i] | s_q.sy2[SY_B + i]))
				& ~|(motor_start_assign[i] & run);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic mtb;
		logic [NSTAGE-1:0] prot;
		mtb  = master_trip_cmd_disable | (master_trip_block_permit & s_q.sy2[SY_MTB]);
		prot = ~superv_only;
		s_d     = s_q;
		s_d.sy1 = raw;
		s_d.sy2 = s_q.sy1;
		s_d.ms_prev = s_q.sy2[SY_MS];
		for (int m = 0; m < NMST; m++) begin
			if (s_q.sy2[SY_MS] && !s_q.ms_prev) begin
				s_d.mst[m] = motor_start_time[m];
			end else if (s_q.mst[m] != PTBL_CNT_RST) begin
				s_d.mst[m] = s_q.mst[m] - TW'(1);
			end
			// flag kept in a flip-flop so the blocking output is not decoded logic
			s_d.msb[m] = (s_d.mst[m] != TW'(PTBL_CNT_RST));
		end
		for (int i = 0; i < NSTAGE; i++) begin
			s_d.alarm[i] = fault_det[i] & en[i];
			s_d.trip[i]  = fault_det[i] & en[i] & (s_q.cnt[i] >= stage_delay[i]);
			if (!(fault_det[i] && en[i])) begin
				s_d.cnt[i] = TW'(PTBL_CNT_RST);
			end else if (s_q.cnt[i] < stage_delay[i]) begin
				s_d.cnt[i] = s_q.cnt[i] + TW'(1);
			end
			s_d.cmd[i] = s_d.trip[i] & ~superv_only[i] & ~trip_cmd_disable[i]
				& ~(trip_block_permit[i] & s_q.sy2[SY_TB + i]) & ~mtb;
		end
		s_d.gal = |(s_d.alarm & prot);
		s_d.gtr = |(s_d.trip & prot);
		s_d.gnd = |(s_d.alarm & prot & ground_stage);
		s_d.pal = '0;
		s_d.ptr = '0;
		for (int i = 0; i < NSTAGE; i++) begin
			if (prot[i] && phase_selective[i]) begin
				s_d.pal = s_d.pal | (fault_phase[i] & {PTBL_NPH{s_d.alarm[i]}});
				s_d.ptr = s_d.ptr | (fault_phase[i] & {PTBL_NPH{s_d.trip[i]}});
			end
		end
		for (int b = 0; b < NBRK; b++) begin
			s_d.brk[b] = |(s_d.cmd & trip_assign[b]);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign stage_alarm           = s_q.alarm;
	assign stage_trip            = s_q.trip;
	assign trip_command          = s_q.cmd;
	assign general_alarm         = s_q.gal;
	assign general_trip          = s_q.gtr;
	assign general_alarm_ground  = s_q.gnd;
	assign general_alarm_phase_a = s_q.pal[PTBL_PH_A];
	assign general_alarm_phase_b = s_q.pal[PTBL_PH_B];
	assign general_alarm_phase_c = s_q.pal[PTBL_PH_C];
	assign general_trip_phase_a  = s_q.ptr[PTBL_PH_A];
	assign general_trip_phase_b  = s_q.ptr[PTBL_PH_B];
	assign general_trip_phase_c  = s_q.ptr[PTBL_PH_C];
	assign breaker_open          = s_q.brk;
	assign motor_start_blocking  = s_q.msb;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic [PTBL_NPH-1:0] ph_alarm_out;
	logic [PTBL_NPH-1:0] ph_trip_out;
	assign ph_alarm_out = {general_alarm_phase_c, general_alarm_phase_b, general_alarm_phase_a};
	assign ph_trip_out  = {general_trip_phase_c, general_trip_phase_b, general_trip_phase_a};

	// per-stage checks
	for (genvar i = 0; i < NSTAGE; i++) begin : g_chk
		alarm_follow_a: assert property ((fault_det[i] && en[i]) |=> stage_alarm[i])
			else $error("stage alarm missing after fault");
		stage_off_a: assert property (!stage_active[i] |=> !stage_alarm[i] && !stage_trip[i])
			else $error("inactive stage produced output");
		trip_delay_a: assert property ($rose(stage_trip[i]) |->
			$past(fault_det[i]) && ($past(s_q.cnt[i]) >= $past(stage_delay[i])))
			else $error("trip before delay elapsed");
		trip_follow_a: assert property ((fault_det[i] && en[i]
			&& s_q.cnt[i] >= stage_delay[i]) |=> stage_trip[i])
			else $error("trip missing after delay");
		restart_a: assert property (!fault_det[i] |=> !stage_trip[i] && s_q.cnt[i] == '0)
			else $error("delay timer not restarted");
		cmd_gate_a: assert property (trip_command[i] |-> stage_trip[i]
			&& !$past(superv_only[i]) && !$past(trip_cmd_disable[i]))
			else $error("trip command while not allowed");
		cmd_issue_a: assert property ((fault_det[i] && en[i]
			&& s_q.cnt[i] >= stage_delay[i] && !superv_only[i] && !trip_cmd_disable[i]
			&& !master_trip_cmd_disable && !(trip_block_permit[i] && s_q.sy2[SY_TB + i])
			&& !(master_trip_block_permit && s_q.sy2[SY_MTB])) |=> trip_command[i])
			else $error("trip command missing");
		superv_cmd_a: assert property (superv_only[i] |=> !trip_command[i])
			else $error("supervision stage issued command");
		cmd_off_a: assert property (trip_cmd_disable[i] |=> !trip_command[i])
			else $error("disabled trip command issued");
		trip_blk_a: assert property ((trip_block_permit[i] && s_q.sy2[SY_TB + i])
			|=> !trip_command[i])
			else $error("trip command not suppressed");
		ext_blk_a: assert property ((ext_block_permit[i]
			&& (s_q.sy2[SY_A + i] || s_q.sy2[SY_B + i])) |=> !stage_alarm[i])
			else $error("blocked stage raised alarm");
		ms_blk_a: assert property (|(motor_start_assign[i] & motor_start_blocking)
			|=> !stage_alarm[i])
			else $error("stage alarm during motor start");
		for (genvar p = 0; p < PTBL_NPH; p++) begin : g_ph
			ph_alarm_a: assert property ((stage_alarm[i] && $past(phase_selective[i])
				&& !$past(superv_only[i]) && $past(fault_phase[i][p])) |-> ph_alarm_out[p])
				else $error("phase alarm missing");
			ph_trip_a: assert property ((stage_trip[i] && $past(phase_selective[i])
				&& !$past(superv_only[i]) && $past(fault_phase[i][p])) |-> ph_trip_out[p])
				else $error("phase trip missing");
		end
	end

	// collective, routing and timer checks
	gen_alarm_a: assert property (general_alarm
		== |(stage_alarm & ~$past(superv_only)))
		else $error("general alarm mismatch");
	gen_trip_a: assert property (general_trip
		== |(stage_trip & ~$past(superv_only)))
		else $error("general trip mismatch");
	superv_gen_a: assert property ((superv_only == '1)
		|=> !general_alarm && !general_trip && breaker_open == '0)
		else $error("supervision stages reached collectives");
	master_off_a: assert property (!master_active |=> !general_alarm && trip_command == '0)
		else $error("output while master inactive");
	master_blk_a: assert property ((master_ext_block_permit
		&& (s_q.sy2[SY_MA] || s_q.sy2[SY_MB])) |=> stage_alarm == '0)
		else $error("master block ineffective");
	master_dis_a: assert property (master_trip_cmd_disable |=> trip_command == '0)
		else $error("trip command while all disabled");
	master_tb_a: assert property ((master_trip_block_permit && s_q.sy2[SY_MTB])
		|=> trip_command == '0)
		else $error("trip command while all blocked");
	for (genvar b = 0; b < NBRK; b++) begin : g_brk
		breaker_a: assert property (breaker_open[b]
			== |(trip_command & $past(trip_assign[b])))
			else $error("breaker route mismatch");
	end
	ground_a: assert property (general_alarm_ground |-> general_alarm)
		else $error("ground alarm without general alarm");
	ground_eq_a: assert property (general_alarm_ground
		== |(stage_alarm & ~$past(superv_only) & $past(ground_stage)))
		else $error("ground alarm mismatch");
	phase_a_a: assert property (|ph_alarm_out |-> general_alarm)
		else $error("phase alarm without general alarm");
	phase_t_a: assert property (|ph_trip_out |-> general_trip)
		else $error("phase trip without general trip");
	mstart_a: assert property ((s_q.sy2[SY_MS] && !s_q.ms_prev)
		|=> s_q.mst[0] == $past(motor_start_time[0]))
		else $error("motor start timer not loaded");
	ms_down_a: assert property ((motor_start_blocking[0]
		&& !(s_q.sy2[SY_MS] && !s_q.ms_prev)) |=> s_q.mst[0] == $past(s_q.mst[0]) - TW'(1))
		else $error("motor start timer not counting");

	// scenario covers
	trip_cov: cover property (fault_det[0] && en[0] ##1 stage_trip[0]);
	cmd_cov: cover property (trip_command[0] ##1 breaker_open[0]);
	mstart_cov: cover property (s_q.sy2[SY_MS] && !s_q.ms_prev ##1 motor_start_blocking[0]);
	gnd_cov: cover property (general_alarm_ground && general_trip);
	supv_cov: cover property (stage_trip[0] && !trip_command[0] && !general_trip);

endmodule : ptbl_core
`default_nettype wire

// File: rtl/ptbl_pkg.sv
package ptbl_pkg;
	// default sizes of the protection frame
	localparam int PTBL_NSTAGE = 4;
	localparam int PTBL_NBRK   = 2;
	localparam int PTBL_NMST   = 2;
	localparam int PTBL_TW     = 16;
	localparam int PTBL_NPH    = 3;
	// phase index within a phase vector
	localparam int PTBL_PH_A   = 0;
	localparam int PTBL_PH_B   = 1;
	localparam int PTBL_PH_C   = 2;
	// reset values
	localparam logic PTBL_FLAG_RST = 1'b0;
	localparam logic [PTBL_TW-1:0] PTBL_CNT_RST = 16'h0000;
endpackage : ptbl_pkg

// File: test/ptbl_blk_src.sv
`timescale 1ns/1ns
`default_nettype none
module ptbl_blk_src (
	input  wire logic        mclk,
	input  wire logic        slow,
	input  wire logic [14:0] req,
	output var  logic [14:0] src
);
	logic [14:0] lag_q;
	// sources are unrelated to the relay clock: they move mid-cycle, promptly or a cycle late
	always @(posedge mclk) begin
		lag_q <= req;
		src   <= #37 (slow ? lag_q : req);
	end
endmodule : ptbl_blk_src
`default_nettype wire

// File: test/protection_trip_block_logic_bench.sv
`timescale 1ns/1ns
`default_nettype none
module protection_trip_block_logic_bench
	import ptbl_pkg::*;
;
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	logic             master_active, master_ext_block_permit, master_trip_cmd_disable;
	logic             master_trip_block_permit, motor_start, slow;
	logic [1:0][15:0] motor_start_time;
	logic [3:0]       fault_det, stage_active, superv_only, phase_selective, ground_stage;
	logic [3:0]       trip_cmd_disable, ext_block_permit, trip_block_permit, mblk;
	logic [3:0][2:0]  fault_phase;
	logic [3:0][15:0] stage_delay;
	logic [3:0][1:0]  motor_start_assign;
	logic [1:0][3:0]  trip_assign;
	logic [14:0]      req;
	logic [63:0]      r;
	wire logic [14:0] src;
	wire logic        master_ext_block_source_a = src[0];
	wire logic        master_ext_block_source_b = src[1];
	wire logic        master_trip_block_source = src[2];
	wire logic [3:0]  ext_block_source_a = src[6:3];
	wire logic [3:0]  ext_block_source_b = src[10:7];
	wire logic [3:0]  trip_block_source = src[14:11];
	wire logic [3:0]  stage_alarm, stage_trip, trip_command;
	wire logic        general_alarm, general_trip, general_alarm_ground;
	wire logic        general_alarm_phase_a, general_alarm_phase_b, general_alarm_phase_c;
	wire logic        general_trip_phase_a, general_trip_phase_b, general_trip_phase_c;
	wire logic [1:0]  breaker_open, motor_start_blocking;
	int               mismatches = 0, checked = 0, cyc = 0, seed = 9;

	ptbl_core ptbl_core_inst (.*);
	ptbl_blk_src ptbl_blk_src_inst (.*);

	always #50 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [3:0] en_f();
		return {4{master_active & ~(master_ext_block_permit & (req[0] | req[1]))}}
			& stage_active & ~(ext_block_permit & (req[6:3] | req[10:7])) & ~mblk;
	endfunction : en_f

	function automatic logic [3:0] cmd_f(input logic [3:0] tr);
		return tr & ~superv_only & ~trip_cmd_disable & ~(trip_block_permit & req[14:11])
			& ~{4{master_trip_cmd_disable | (master_trip_block_permit & req[2])}};
	endfunction : cmd_f

	function automatic logic [2:0] ph_f(input logic [3:0] v);
		logic [2:0] p;
		p = 3'h0;
		for (int i = 0; i < 4; i++) if (v[i] & phase_selective[i] & ~superv_only[i]) p |= fault_phase[i];
		return p;
	endfunction : ph_f

	// fault held past the delay of 3, checked at alarm, just before and at expiry
	task fault_run(input logic [3:0] fd);
		logic [3:0] al, cm;
		al = en_f() & fd;
		cm = cmd_f(al);
		@(posedge mclk) fault_det <= fd;
		@(posedge mclk) #1;
		chk(stage_alarm, al);
		chk(general_alarm, |(al & ~superv_only));
		chk(general_alarm_ground, |(al & ~superv_only & ground_stage));
		chk({general_alarm_phase_c, general_alarm_phase_b, general_alarm_phase_a}, ph_f(al));
		repeat (2) @(posedge mclk);
		#1 chk(stage_trip, 4'h0);
		@(posedge mclk) #1;
		chk(stage_trip, al);
		chk(general_trip, |(al & ~superv_only));
		chk({general_trip_phase_c, general_trip_phase_b, general_trip_phase_a}, ph_f(al));
		chk(trip_command, cm);
		chk(breaker_open, {|(cm & trip_assign[1]), |(cm & trip_assign[0])});
		@(posedge mclk) fault_det <= 4'h0;
		repeat (2) @(posedge mclk);
	endtask : fault_run

	task give_verdict();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		{master_active, master_ext_block_permit, master_trip_cmd_disable, master_trip_block_permit,
			motor_start, slow, fault_det, superv_only, phase_selective, ground_stage,
			trip_cmd_disable, ext_block_permit, trip_block_permit, mblk, fault_phase,
			motor_start_assign, trip_assign, req, motor_start_time} = '0;
		stage_active = 4'hf;
		stage_delay = {4{16'h0003}};
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk) #1;
		chk({stage_alarm, stage_trip, trip_command, general_alarm, general_trip, breaker_open}, 16'h0000);
		@(posedge mclk) master_active <= 1'b1;
		// fault dropped for one cycle after two counts, then held again
		@(posedge mclk) fault_det <= 4'hf;
		repeat (2) @(posedge mclk);
		fault_det <= 4'h0;
		fault_run(4'hf);
		@(posedge mclk) begin
			motor_start_time <= {16'h0014, 16'h0028};
			motor_start_assign <= {2'b00, 2'b00, 2'b10, 2'b01};
			motor_start <= 1'b1;
		end
		repeat (5) @(posedge mclk);
		#1 chk(motor_start_blocking, 2'b11);
		mblk = 4'h3;
		fault_run(4'hf);
		motor_start <= 1'b0;
		repeat (20) @(posedge mclk);
		#1 chk(motor_start_blocking, 2'b01);
		repeat (20) @(posedge mclk);
		#1 chk(motor_start_blocking, 2'b00);
		mblk = 4'h0;
		fault_run(4'hf);
		// reset while tripped clears every output at once
		@(posedge mclk) fault_det <= 4'hf;
		repeat (5) @(posedge mclk);
		#1 chk(stage_trip, en_f());
		@(posedge mclk) rst <= 1'b1;
		#1 chk({stage_alarm, stage_trip, trip_command, general_alarm, general_trip, breaker_open},
			16'h0000);
		@(posedge mclk) begin
			rst <= 1'b0;
			fault_det <= 4'h0;
		end
		// random settings and block sources; the first pass has the master inactive
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			r = {$random(seed), $random(seed)};
			{stage_active, superv_only, phase_selective, ground_stage, trip_cmd_disable,
				ext_block_permit, trip_block_permit, trip_assign} <= r[35:0];
			master_active <= (i != 0) && (r[38:36] != 3'h0);
			master_ext_block_permit <= r[39];
			master_trip_cmd_disable <= r[40] & r[41];
			master_trip_block_permit <= r[42];
			slow <= r[43];
			fault_phase <= r[55:44];
			req <= 15'($random(seed));
			repeat (4) @(posedge mclk);
			fault_run(4'($random(seed)));
		end
		give_verdict();
	end
endmodule : protection_trip_block_logic_bench
`default_nettype wire
